// ==== verilog/tmc_pkg.sv ====
package tmc_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Mode register keeps its printed offset as an index; byte address is four times it
	localparam logic [ADDR_W-1:0] TMS_IDX  = 12'h089;
	localparam logic [ADDR_W-1:0] TMS_ADDR = 12'h224;
	localparam logic [ADDR_W-1:0] RUN_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] IRQ_ADDR = 12'h004;
	localparam logic [ADDR_W-1:0] CLK_ADDR = 12'h008;
	localparam logic [ADDR_W-1:0] STS_ADDR = 12'h00c;

	localparam logic [7:0] TMS_RESET = 8'h00;
	localparam logic [1:0] RUN_RESET = 2'h0;
	localparam logic [1:0] POL_RESET = 2'h0;
	localparam logic [1:0] CLK_RESET = 2'h0;

	// Fields of timer_mode_select
	localparam int ONE_GATE_BIT  = 7;
	localparam int ONE_SRC_BIT   = 6;
	localparam int ONE_MODE_HI   = 5;
	localparam int ONE_MODE_LO   = 4;
	localparam int ZERO_GATE_BIT = 3;
	localparam int ZERO_SRC_BIT  = 2;
	localparam int ZERO_MODE_HI  = 1;
	localparam int ZERO_MODE_LO  = 0;

	// Fields of the run, polarity and status words
	localparam int ONE_BIT  = 1;
	localparam int ZERO_BIT = 0;
	// Fields of timer_clock_control
	localparam int ONE_CLK_BIT  = 4;
	localparam int ZERO_CLK_BIT = 3;
	// Status word: enables sit above the pin-active bits
	localparam int STS_EN_SHIFT = 2;

	localparam logic [1:0] MODE_13BIT    = 2'h0;
	localparam logic [1:0] MODE_16BIT    = 2'h1;
	localparam logic [1:0] MODE_8BIT_AR  = 2'h2;
	localparam logic [1:0] MODE_INACTIVE = 2'h3;

	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

endpackage : tmc_pkg

// ==== verilog/tmc_ctrl_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface tmc_ctrl_if;
	logic       run;
	logic       pin_gate;
	logic       count_source;
	logic [1:0] mode;
	logic       clock_choice;
	logic       polarity;

	modport ctl (output run, pin_gate, count_source, mode, clock_choice, polarity);
	modport tmr (input run, pin_gate, count_source, mode, clock_choice, polarity);
endinterface : tmc_ctrl_if

`default_nettype wire

// ==== verilog/tmc_timer_gate.sv ====
`timescale 1ns/100ps
`default_nettype none

module tmc_timer_gate #(
	parameter bit MODE3_INACTIVE = 1'b0
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	tmc_ctrl_if.tmr    cfg,
	input  wire logic  ext_irq_pin,
	input  wire logic  count_pin,
	input  wire logic  prescale_tick,
	output logic       irq_active,
	output logic       count_en,
	output logic       inc
);
	import tmc_pkg::*;

	logic cur_q;
	logic cur_d;
	logic prev_q;
	logic prev_d;
	logic inc_q;
	logic inc_d;
	logic fall;
	logic tick;
	logic go;

	always_comb
	begin
		irq_active = (ext_irq_pin == cfg.polarity);
		count_en   = cfg.run && (!cfg.pin_gate || irq_active);
		go         = count_en && !(MODE3_INACTIVE && cfg.mode == MODE_INACTIVE);
		cur_d      = count_pin;
		prev_d     = cur_q;
		fall       = prev_q && !cur_q;
		// Clock choice only matters in timer function
		tick       = cfg.count_source ? fall : (cfg.clock_choice ? 1'b1 : prescale_tick);
		inc_d      = go && tick;
	end

	// Both samples start high, so a count pin that is low when reset ends reads as one falling edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_q  <= 1'b1;
			prev_q <= 1'b1;
			inc_q  <= 1'b0;
		end
		else
		begin
			cur_q  <= cur_d;
			prev_q <= prev_d;
			inc_q  <= inc_d;
		end
	end

	assign inc = inc_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_pin_fall;
		count_pin ##1 !count_pin;
	endsequence

	a_gate_open_run: assert property (!cfg.pin_gate && cfg.run |-> count_en)
		else $error("ungated timer with run set is not enabled");
	a_gate_pin_block: assert property (cfg.pin_gate && !irq_active |-> !count_en)
		else $error("gated timer counts while pin inactive");
	a_gate_pin_pass: assert property (cfg.pin_gate && cfg.run && irq_active |-> count_en)
		else $error("gated timer blocked while pin active and run set");
	a_pin_polarity: assert property (cfg.pin_gate && cfg.run && ext_irq_pin != cfg.polarity
		|-> !count_en)
		else $error("wrong pin level accepted as active");
	a_fall_one_inc: assert property (s_pin_fall ##1 (cfg.count_source && go) |=> inc)
		else $error("falling edge on count pin gave no increment");
	a_no_edge_quiet: assert property (cfg.count_source && $stable(count_pin) [*3] |=> !inc)
		else $error("increment without a count pin edge");
	a_sysclk_every: assert property (!cfg.count_source && cfg.clock_choice && go |=> inc)
		else $error("system clock choice missed a cycle");
	a_prescale_wait: assert property (!cfg.count_source && !cfg.clock_choice
		&& !prescale_tick |=> !inc)
		else $error("prescaled timer advanced without a tick");
	a_mode3_idle: assert property (MODE3_INACTIVE && cfg.mode == MODE_INACTIVE |=> !inc)
		else $error("inactive mode still increments");

endmodule : tmc_timer_gate

`default_nettype wire

// ==== verilog/tmc_top.sv ====
// Notes on behaviour
// - Timer one ungated: run bit alone enables.
// - Timer one gated: run and active pin.
// - Count source set: count pin falling edges.
// - Timer one mode: 13,16,8-reload, inactive.
// - Timer zero ungated: run bit alone enables.
// - Timer zero gated: run and active pin.
// - Gate/source bits at 7,6,3,2.
// - Pin active level follows polarity bit.
// - Timer function: prescaled or system clock.
`timescale 1ns/100ps
`default_nettype none

module tmc_top (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [tmc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [tmc_pkg::DATA_W-1:0]   pwdata,
	output logic      [tmc_pkg::DATA_W-1:0]   prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         ext_irq_pin_one,
	input  wire logic                         ext_irq_pin_zero,
	input  wire logic                         count_pin_one,
	input  wire logic                         count_pin_zero,
	input  wire logic                         prescale_tick,
	output logic                              timer_one_count_en,
	output logic                              timer_zero_count_en,
	output logic                              timer_one_inc,
	output logic                              timer_zero_inc,
	output logic      [1:0]                   timer_one_mode,
	output logic      [1:0]                   timer_zero_mode
);
	import tmc_pkg::*;

	logic [7:0]        tms_q;
	logic [7:0]        tms_d;
	logic [1:0]        run_q;
	logic [1:0]        run_d;
	logic [1:0]        pol_q;
	logic [1:0]        pol_d;
	logic [1:0]        clk_q;
	logic [1:0]        clk_d;
	logic [DATA_W-1:0] prdata_q;
	logic [DATA_W-1:0] prdata_d;
	logic              wr_en;
	logic              setup;
	logic              one_active;
	logic              zero_active;
	logic [3:0]        status;

	tmc_ctrl_if one_cfg ();
	tmc_ctrl_if zero_cfg ();

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == TMS_ADDR) || (a == RUN_ADDR) || (a == IRQ_ADDR)
			|| (a == CLK_ADDR) || (a == STS_ADDR);
	endfunction : reg_hit

	// Bus: zero wait states, read data captured during setup
	always_comb
	begin
		setup   = psel && !penable;
		wr_en   = psel && penable && pwrite && reg_hit(paddr);
		pready  = psel && penable;
		pslverr = psel && penable && !reg_hit(paddr);
	end

	always_comb
	begin
		tms_d = tms_q;
		run_d = run_q;
		pol_d = pol_q;
		clk_d = clk_q;
		if (wr_en)
		begin
			case (paddr)
				TMS_ADDR: tms_d = pwdata[7:0];
				RUN_ADDR: run_d = pwdata[1:0];
				IRQ_ADDR: pol_d = pwdata[1:0];
				CLK_ADDR: clk_d = {pwdata[ONE_CLK_BIT], pwdata[ZERO_CLK_BIT]};
				default:  tms_d = tms_q;
			endcase
		end
	end

	always_comb
	begin
		prdata_d = prdata_q;
		if (setup && !pwrite)
		begin
			prdata_d = RD_ZERO;
			case (paddr)
				TMS_ADDR: prdata_d[7:0] = tms_q;
				RUN_ADDR: prdata_d[1:0] = run_q;
				IRQ_ADDR: prdata_d[1:0] = pol_q;
				CLK_ADDR:
				begin
					prdata_d[ONE_CLK_BIT]  = clk_q[ONE_BIT];
					prdata_d[ZERO_CLK_BIT] = clk_q[ZERO_BIT];
				end
				STS_ADDR: prdata_d[3:0] = status;
				default:  prdata_d = RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tms_q    <= TMS_RESET;
			run_q    <= RUN_RESET;
			pol_q    <= POL_RESET;
			clk_q    <= CLK_RESET;
			prdata_q <= RD_ZERO;
		end
		else
		begin
			tms_q    <= tms_d;
			run_q    <= run_d;
			pol_q    <= pol_d;
			clk_q    <= clk_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	// Field fan-out to each timer
	always_comb
	begin
		one_cfg.run           = run_q[ONE_BIT];
		one_cfg.pin_gate      = tms_q[ONE_GATE_BIT];
		one_cfg.count_source  = tms_q[ONE_SRC_BIT];
		one_cfg.mode          = tms_q[ONE_MODE_HI:ONE_MODE_LO];
		one_cfg.clock_choice  = clk_q[ONE_BIT];
		one_cfg.polarity      = pol_q[ONE_BIT];
		zero_cfg.run          = run_q[ZERO_BIT];
		zero_cfg.pin_gate     = tms_q[ZERO_GATE_BIT];
		zero_cfg.count_source = tms_q[ZERO_SRC_BIT];
		zero_cfg.mode         = tms_q[ZERO_MODE_HI:ZERO_MODE_LO];
		zero_cfg.clock_choice = clk_q[ZERO_BIT];
		zero_cfg.polarity     = pol_q[ZERO_BIT];
	end

	// Only timer one goes idle in mode 3; timer zero's split mode lives elsewhere
	tmc_timer_gate #(
		.MODE3_INACTIVE (1'b1)
	) u_one (
		.pclk          (pclk),
		.presetn       (presetn),
		.cfg           (one_cfg.tmr),
		.ext_irq_pin   (ext_irq_pin_one),
		.count_pin     (count_pin_one),
		.prescale_tick (prescale_tick),
		.irq_active    (one_active),
		.count_en      (timer_one_count_en),
		.inc           (timer_one_inc)
	);

	tmc_timer_gate #(
		.MODE3_INACTIVE (1'b0)
	) u_zero (
		.pclk          (pclk),
		.presetn       (presetn),
		.cfg           (zero_cfg.tmr),
		.ext_irq_pin   (ext_irq_pin_zero),
		.count_pin     (count_pin_zero),
		.prescale_tick (prescale_tick),
		.irq_active    (zero_active),
		.count_en      (timer_zero_count_en),
		.inc           (timer_zero_inc)
	);

	always_comb
	begin
		status          = {timer_one_count_en, timer_zero_count_en, one_active, zero_active};
		timer_one_mode  = tms_q[ONE_MODE_HI:ONE_MODE_LO];
		timer_zero_mode = tms_q[ZERO_MODE_HI:ZERO_MODE_LO];
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_mode_write;
		psel && !penable && pwrite && paddr == TMS_ADDR ##1 psel && penable;
	endsequence

	sequence s_pol_write;
		psel && !penable && pwrite && paddr == IRQ_ADDR ##1 psel && penable;
	endsequence

	sequence s_clk_write;
		psel && !penable && pwrite && paddr == CLK_ADDR ##1 psel && penable;
	endsequence

	// Read data are latched in setup, so they show one edge later
	sequence s_mode_read;
		psel && !penable && !pwrite && paddr == TMS_ADDR;
	endsequence

	a_mode_reg_write: assert property (s_mode_write |=> tms_q == $past(pwdata[7:0], 1))
		else $error("mode register did not take written byte");
	a_mode_one_field: assert property (s_mode_write
		|=> timer_one_mode == $past(pwdata[5:4], 1))
		else $error("timer one mode not from bits 5..4");
	a_mode_zero_field: assert property (s_mode_write
		|=> timer_zero_mode == $past(pwdata[1:0], 1))
		else $error("timer zero mode not from bits 1..0");
	a_mode_readback: assert property (s_mode_read
		|=> prdata == {24'h00_0000, $past(tms_q, 1)})
		else $error("mode register read returned wrong data");
	a_pol_write_in: assert property (s_pol_write |=> pol_q == $past(pwdata[1:0], 1))
		else $error("polarity bits did not take written value");
	a_clk_write_in: assert property (s_clk_write
		|=> clk_q == {$past(pwdata[4], 1), $past(pwdata[3], 1)})
		else $error("clock choice bits not taken from bits 4 and 3");
	// Refused writes must leave every register as it was
	a_unmapped_err: assert property (psel && penable && !reg_hit(paddr)
		|-> pslverr && pready ##1 $stable(tms_q) && $stable(run_q) && $stable(pol_q)
		&& $stable(clk_q))
		else $error("unmapped access not flagged or not refused");

endmodule : tmc_top

`default_nettype wire

// ==== testbench/test_timer_mode_control.sv ====
`timescale 1ns/100ps
`default_nettype none

`define CK(nm, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) \
		begin \
			err_count++; \
			$display("mismatch %s expected %0h seen %0h", nm, e, g); \
		end \
	end

module test_timer_mode_control;
	import tmc_pkg::*;

	logic              pclk;
	logic              presetn;
	logic [ADDR_W-1:0] paddr;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              pin1;
	logic              pin0;
	logic              cnt1;
	logic              cnt0;
	logic              tick;
	logic              en1;
	logic              en0;
	logic              inc1;
	logic              inc0;
	logic [1:0]        mode1;
	logic [1:0]        mode0;
	logic [DATA_W-1:0] rd;
	logic              se;
	int                err_count;
	int                checked;
	int                n;

	tmc_top i_tmc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_irq_pin_one(pin1),
		.ext_irq_pin_zero(pin0), .count_pin_one(cnt1), .count_pin_zero(cnt0),
		.prescale_tick(tick), .timer_one_count_en(en1), .timer_zero_count_en(en0),
		.timer_one_inc(inc1), .timer_zero_inc(inc0), .timer_one_mode(mode1),
		.timer_zero_mode(mode0));

	always #2.5 pclk = ~pclk;

	task wrap_up;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// Request held until pready is sampled; no wait-state count assumed
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 16)
		begin
			err_count++;
			wrap_up;
		end
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Counts inc pulses; optional tick on alternate cycles of the first eight
	// Unknown inc spoils the count; returns on an edge so callers drive there
	task count(input bit one, input bit tk, output int c);
		c = 0;
		for (int i = 0; i < 10; i++)
		begin
			@(posedge pclk);
			tick <= tk && i < 8 && i % 2 == 0;
			#1;
			if ((one ? inc1 : inc0) === 1'b1)
				c++;
			else if ((one ? inc1 : inc0) !== 1'b0)
				c += 100;
		end
		@(posedge pclk);
	endtask : count

	task t_reset;
		apb(1'b0, TMS_ADDR, 32'h0);
		`CK("mode reg", 32'h0, rd)
		`CK("mapped slverr", 1'b0, se)
		`CK("modes", 4'h0, {mode1, mode0})
		`CK("enables", 2'h0, {en1, en0})
		apb(1'b0, 12'h010, 32'h0);
		`CK("unmapped", 33'h1_0000_0000, {se, rd})
	endtask : t_reset

	task t_modes;
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, TMS_ADDR, 32'hffff_ff00 | (m << 4) | (3 - m));
			apb(1'b0, TMS_ADDR, 32'h0);
			`CK("readback", 32'(m << 4 | (3 - m)), rd)
			`CK("mode one", 2'(m), mode1)
			`CK("mode zero", 2'(3 - m), mode0)
		end
	endtask : t_modes

	task t_gate;
		apb(1'b1, RUN_ADDR, 32'h3);
		apb(1'b1, TMS_ADDR, 32'h0);
		repeat (3) @(posedge pclk);
		`CK("ungated", 2'h3, {en1, en0})
		apb(1'b1, TMS_ADDR, 32'h88);
		for (int p = 0; p < 4; p++)
		begin
			apb(1'b1, IRQ_ADDR, 32'(p[1] ? 2'h3 : 2'h0));
			pin1 <= p[0];
			pin0 <= ~p[0];
			repeat (3) @(posedge pclk);
			`CK("gated", {p[0] == p[1], p[0] != p[1]}, {en1, en0})
			apb(1'b0, STS_ADDR, 32'h0);
			`CK("status", 32'({p[0] == p[1], p[0] != p[1], p[0] == p[1], p[0] != p[1]}), rd)
		end
		apb(1'b1, RUN_ADDR, 32'h0);
		repeat (3) @(posedge pclk);
		`CK("stopped", 2'h0, {en1, en0})
	endtask : t_gate

	task t_count;
		apb(1'b1, RUN_ADDR, 32'h3);
		apb(1'b1, CLK_ADDR, 32'h10);
		apb(1'b0, CLK_ADDR, 32'h0);
		`CK("clock reg", 32'h10, rd)
		apb(1'b1, TMS_ADDR, 32'h40);
		count(1'b1, 1'b0, n);
		`CK("no edge", 0, n)
		cnt1 <= 1'b0;
		count(1'b1, 1'b0, n);
		`CK("one edge", 1, n)
		cnt1 <= 1'b1;
		apb(1'b1, TMS_ADDR, 32'h70);
		cnt1 <= 1'b0;
		count(1'b1, 1'b0, n);
		`CK("inactive", 0, n)
		apb(1'b1, TMS_ADDR, 32'h00);
		count(1'b1, 1'b0, n);
		`CK("sysclk", 10, n)
		apb(1'b1, CLK_ADDR, 32'h0);
		count(1'b1, 1'b1, n);
		`CK("prescaled", 4, n)
		count(1'b0, 1'b1, n);
		`CK("zero prescaled", 4, n)
		apb(1'b1, TMS_ADDR, 32'h04);
		cnt0 <= 1'b0;
		count(1'b0, 1'b0, n);
		`CK("zero counter", 1, n)
	endtask : t_count

	// Second reset in mid-run with count pins low and registers loaded
	task t_reset_mid;
		apb(1'b1, TMS_ADDR, 32'hcc);
		apb(1'b1, IRQ_ADDR, 32'h3);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, RUN_ADDR, 32'h0);
		`CK("run after reset", 32'h0, rd)
		apb(1'b0, IRQ_ADDR, 32'h0);
		`CK("polarity after reset", 32'h0, rd)
		apb(1'b0, TMS_ADDR, 32'h0);
		`CK("mode after reset", 32'h0, rd)
		`CK("enables after reset", 2'h0, {en1, en0})
	endtask : t_reset_mid

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		paddr = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = '0;
		{pin1, pin0, tick} = 3'h0;
		{cnt1, cnt0} = 2'h3;
		err_count = 0;
		checked = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_modes;
		t_gate;
		t_count;
		t_reset_mid;
		wrap_up;
	end
endmodule : test_timer_mode_control

`default_nettype wire
